// File: core/pcd_map.svh
// Offsets, opcodes, lengths, field values and reset values of the decoder
`ifndef PCD_MAP_SVH
`define PCD_MAP_SVH

// ----------------------------------------------------------------------
// Message opcodes and total lengths
// ----------------------------------------------------------------------
`define PCD_OP_TRIP_CLR 8'h82
`define PCD_OP_RESTART 8'h84
`define PCD_OP_BATTLE 8'h86
`define PCD_OP_LIMIT 8'h90
`define PCD_OP_GROUP 8'h92
`define PCD_LEN_TRIP_CLR 16'h0004
`define PCD_LEN_RESTART 16'h0003
`define PCD_LEN_BATTLE 16'h0005
`define PCD_LEN_LIMIT 16'h000a
`define PCD_LEN_GROUP 16'h000c
`define PCD_LEN_RESP 16'h0004
`define PCD_LEN_HDR 16'h0003
`define PCD_SEL_GRP_BASE 8'h80
`define PCD_ST_ACK 8'h00
`define PCD_ST_NACK 8'h01
`define PCD_ST_WPROT 8'h02
`define PCD_THERM_MIN 16'h0001
`define PCD_THERM_MAX 16'h1388
`define PCD_AMP_RES_MASK 16'hfff8

// ----------------------------------------------------------------------
// APB register offsets and reset values
// ----------------------------------------------------------------------
`define PCD_REG_IRQ_STAT 8'h00
`define PCD_REG_IRQ_MASK 8'h04
`define PCD_REG_TRIP 8'h08
`define PCD_REG_BATTLE 8'h0c
`define PCD_REG_GROUP 8'h10
`define PCD_REG_LIM_SEL 8'h14
`define PCD_REG_LIM_CUR 8'h18
`define PCD_REG_LIM_THERM 8'h1c
`define PCD_IRQ_CMD_OK 0
`define PCD_IRQ_CMD_REJ 1
`define PCD_IRQ_TRIP 2
`define PCD_IRQ_RESTART 3
`define PCD_RST_MASK 4'h0
`define PCD_RST_LIMIT 16'h0000

`endif

// File: core/pcd_pkg.sv
// Types shared by the channel command decoder
package pcd_pkg;
  typedef enum logic [2:0] {
    PCD_S_OP = 3'b000,
    PCD_S_LEN_HI = 3'b001,
    PCD_S_LEN_LO = 3'b010,
    PCD_S_PAY = 3'b011,
    PCD_S_EXEC = 3'b100,
    PCD_S_RESP = 3'b101
  } pcd_state_t;

  typedef enum logic [1:0] {
    PCD_TRIP_NONE = 2'b00,
    PCD_TRIP_OVL = 2'b01,
    PCD_TRIP_SC = 2'b10
  } pcd_trip_t;
endpackage

// File: core/pcd_decoder.sv
// Channel command decoder: message parser, channel state and APB slave
`include "pcd_map.svh"
module pcd_decoder #(
  parameter int NCH = 8,
  parameter int PBUF = 9
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] ovl_event,
  input wire logic [7:0] sc_event,
  input wire logic update_busy,
  input wire logic nv_write_protect,
  output logic [7:0] battle_mode,
  output logic [7:0] sc_retry,
  output logic restart,
  output logic update_abort,
  output logic irq
);
  import pcd_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pcd_state_t state, next_state;
  logic [7:0] op, next_op;
  logic [15:0] len, next_len;
  logic [15:0] cnt, next_cnt;
  logic [7:0] pbuf [PBUF];
  logic [7:0] next_pbuf [PBUF];
  logic [7:0] status, next_status;
  logic [1:0] tx_idx, next_tx_idx;
  logic next_rx_ready, next_tx_valid;
  logic [7:0] next_tx_data;
  pcd_trip_t trip [NCH];
  pcd_trip_t next_trip [NCH];
  logic [3:0] grp [NCH];
  logic [3:0] next_grp [NCH];
  logic [15:0] lim_ovl [NCH];
  logic [15:0] lim_sc [NCH];
  logic [15:0] lim_thr [NCH];
  logic [15:0] next_lim_ovl [NCH];
  logic [15:0] next_lim_sc [NCH];
  logic [15:0] next_lim_thr [NCH];
  logic [7:0] next_battle, next_sc_retry;
  logic next_restart, next_update_abort;
  logic [3:0] evt, next_evt;

  // Expected total length per opcode, zero when not ours
  function automatic logic [15:0] exp_len(input logic [7:0] code);
    unique case (code)
      `PCD_OP_TRIP_CLR: exp_len = `PCD_LEN_TRIP_CLR;
      `PCD_OP_RESTART: exp_len = `PCD_LEN_RESTART;
      `PCD_OP_BATTLE: exp_len = `PCD_LEN_BATTLE;
      `PCD_OP_LIMIT: exp_len = `PCD_LEN_LIMIT;
      `PCD_OP_GROUP: exp_len = `PCD_LEN_GROUP;
      default: exp_len = 16'h0000;
    endcase
  endfunction

  // Selector to channel mask; bit 8 flags a legal selector
  function automatic logic [8:0] sel_decode(input logic [7:0] sel,
                                            input logic [3:0] g [NCH]);
    logic [8:0] r;
    r = 9'h000;
    if (sel >= 8'h01 && sel <= 8'h08) begin
      r[8] = 1'b1;
      r[sel[3:0] - 4'h1] = 1'b1;
    end else if (sel >= 8'h81 && sel <= 8'h88) begin
      r[8] = 1'b1;
      for (int i = 0; i < NCH; i++) begin
        r[i] = (g[i] == 4'(sel - `PCD_SEL_GRP_BASE));
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Message parser, executor and channel state
  // ----------------------------------------------------------------------
  // Next-state logic; unknown opcodes are consumed silently
  always_comb begin
    logic rx_hs;
    logic [8:0] dec;
    logic [7:0] clr;
    logic ok;
    logic [15:0] ovl_f, sc_f, thr_f;
    logic [3:0] gn;
    logic stop;
    logic [7:0] gmask;
    rx_hs = rx_valid && rx_ready;
    dec = sel_decode(pbuf[0], grp);
    clr = 8'h00;
    ok = 1'b0;
    ovl_f = {pbuf[1], pbuf[2]};
    sc_f = {pbuf[3], pbuf[4]};
    thr_f = {pbuf[5], pbuf[6]};
    gn = pbuf[0][3:0];
    stop = 1'b0;
    gmask = 8'h00;
    next_state = state;
    next_op = op;
    next_len = len;
    next_cnt = cnt;
    next_pbuf = pbuf;
    next_status = status;
    next_tx_idx = tx_idx;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_trip = trip;
    next_grp = grp;
    next_lim_ovl = lim_ovl;
    next_lim_sc = lim_sc;
    next_lim_thr = lim_thr;
    next_battle = battle_mode;
    next_sc_retry = 8'h00;
    next_restart = 1'b0;
    next_update_abort = 1'b0;
    next_evt = 4'h0;
    unique case (state)
      PCD_S_OP: begin
        if (rx_hs) begin
          next_op = rx_data;
          next_state = PCD_S_LEN_HI;
        end
      end
      PCD_S_LEN_HI: begin
        if (rx_hs) begin
          next_len = {rx_data, 8'h00};
          next_state = PCD_S_LEN_LO;
        end
      end
      PCD_S_LEN_LO: begin
        if (rx_hs) begin
          next_len = {len[15:8], rx_data};
          next_cnt = 16'h0000;
          next_pbuf = '{default: 8'h00};
          if ({len[15:8], rx_data} <= `PCD_LEN_HDR) begin
            next_state = PCD_S_EXEC;
          end else begin
            next_state = PCD_S_PAY;
          end
        end
      end
      PCD_S_PAY: begin
        if (rx_hs) begin
          // Overlong payloads are drained, only the head is kept
          if (cnt < 16'(PBUF)) begin
            next_pbuf[cnt[3:0]] = rx_data;
          end
          next_cnt = cnt + 16'h0001;
          if (cnt + 16'h0001 == len - `PCD_LEN_HDR) begin
            next_state = PCD_S_EXEC;
          end
        end
      end
      PCD_S_EXEC: begin
        unique case (op)
          `PCD_OP_TRIP_CLR: begin
            ok = dec[8];
            if (ok && len == exp_len(op)) begin
              clr = dec[7:0];
            end
          end
          `PCD_OP_RESTART: begin
            ok = 1'b1;
            if (len == exp_len(op)) begin
              next_restart = 1'b1;
              next_update_abort = update_busy;
            end
          end
          `PCD_OP_BATTLE: begin
            ok = dec[8] && pbuf[1] <= 8'h01;
            if (ok && len == exp_len(op)) begin
              for (int i = 0; i < NCH; i++) begin
                if (dec[i]) begin
                  next_battle[i] = pbuf[1][0];
                end
              end
            end
          end
          `PCD_OP_LIMIT: begin
            ok = dec[8] && !ovl_f[15] && !sc_f[15] &&
                 $signed(thr_f) >= $signed(`PCD_THERM_MIN) &&
                 $signed(thr_f) <= $signed(`PCD_THERM_MAX);
            if (ok && len == exp_len(op)) begin
              for (int i = 0; i < NCH; i++) begin
                if (dec[i]) begin
                  // Kept in 0.0625A units, trimmed to 0.5A steps
                  next_lim_ovl[i] = ovl_f & `PCD_AMP_RES_MASK;
                  next_lim_sc[i] = sc_f & `PCD_AMP_RES_MASK;
                  next_lim_thr[i] = thr_f;
                end
              end
            end
          end
          `PCD_OP_GROUP: begin
            ok = gn != 4'h0 && pbuf[0] <= 8'h08;
            for (int k = 1; k < PBUF; k++) begin
              if (pbuf[k] == 8'h00) begin
                stop = 1'b1;
              end else if (!stop) begin
                if (pbuf[k] > 8'h08) begin
                  ok = 1'b0;
                end else begin
                  gmask[pbuf[k][2:0] - 3'h1] = 1'b1;
                end
              end
            end
            if (ok && len == exp_len(op)) begin
              // Group is replaced by the new list
              for (int i = 0; i < NCH; i++) begin
                if (gmask[i]) begin
                  next_grp[i] = gn;
                end else if (grp[i] == gn) begin
                  next_grp[i] = 4'h0;
                end
              end
            end
          end
          default: ok = 1'b0;
        endcase
        ok = ok && len == exp_len(op);
        if (exp_len(op) != 16'h0000) begin
          if (!ok) begin
            next_status = `PCD_ST_NACK;
          end else if (op == `PCD_OP_LIMIT && nv_write_protect) begin
            next_status = `PCD_ST_WPROT;
          end else begin
            next_status = `PCD_ST_ACK;
          end
          next_evt[`PCD_IRQ_CMD_OK] = ok;
          next_evt[`PCD_IRQ_CMD_REJ] = !ok;
          next_evt[`PCD_IRQ_RESTART] = ok && op == `PCD_OP_RESTART;
          next_tx_valid = 1'b1;
          next_tx_data = op + 8'h01;
          next_tx_idx = 2'h0;
          next_state = PCD_S_RESP;
        end else begin
          next_state = PCD_S_OP;
        end
      end
      PCD_S_RESP: begin
        if (tx_ready) begin
          next_tx_idx = tx_idx + 2'h1;
          unique case (tx_idx)
            2'h0: next_tx_data = 8'(`PCD_LEN_RESP >> 8);
            2'h1: next_tx_data = 8'(`PCD_LEN_RESP & 16'h00ff);
            2'h2: next_tx_data = status;
            2'h3: begin
              next_tx_valid = 1'b0;
              next_state = PCD_S_OP;
            end
          endcase
        end
      end
      default: next_state = PCD_S_OP;
    endcase
    // Trip latching; a short in the clear cycle still lands, an overload on an already tripped channel does not
    // Faults see the mode already in force, not one set at this edge
    for (int i = 0; i < NCH; i++) begin
      if (clr[i]) begin
        next_trip[i] = PCD_TRIP_NONE;
      end
      if (sc_event[i] && battle_mode[i]) begin
        next_sc_retry[i] = 1'b1;
      end else if (sc_event[i]) begin
        next_trip[i] = PCD_TRIP_SC;
        next_evt[`PCD_IRQ_TRIP] = 1'b1;
      end else if (ovl_event[i] && !battle_mode[i] &&
                   trip[i] == PCD_TRIP_NONE) begin
        next_trip[i] = PCD_TRIP_OVL;
        next_evt[`PCD_IRQ_TRIP] = 1'b1;
      end
    end
    next_rx_ready = next_state inside {PCD_S_OP, PCD_S_LEN_HI,
                                       PCD_S_LEN_LO, PCD_S_PAY};
  end

  // Parser and channel registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PCD_S_OP;
      op <= 8'h00;
      len <= 16'h0000;
      cnt <= 16'h0000;
      pbuf <= '{default: 8'h00};
      status <= 8'h00;
      tx_idx <= 2'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      rx_ready <= 1'b0;
      trip <= '{default: PCD_TRIP_NONE};
      grp <= '{default: 4'h0};
      lim_ovl <= '{default: `PCD_RST_LIMIT};
      lim_sc <= '{default: `PCD_RST_LIMIT};
      lim_thr <= '{default: `PCD_RST_LIMIT};
      battle_mode <= 8'h00;
      sc_retry <= 8'h00;
      restart <= 1'b0;
      update_abort <= 1'b0;
      evt <= 4'h0;
    end else begin
      state <= next_state;
      op <= next_op;
      len <= next_len;
      cnt <= next_cnt;
      pbuf <= next_pbuf;
      status <= next_status;
      tx_idx <= next_tx_idx;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      rx_ready <= next_rx_ready;
      trip <= next_trip;
      grp <= next_grp;
      lim_ovl <= next_lim_ovl;
      lim_sc <= next_lim_sc;
      lim_thr <= next_lim_thr;
      battle_mode <= next_battle;
      sc_retry <= next_sc_retry;
      restart <= next_restart;
      update_abort <= next_update_abort;
      evt <= next_evt;
    end
  end

  // ----------------------------------------------------------------------
  // APB slave and interrupt
  // ----------------------------------------------------------------------
  logic [3:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [2:0] lim_sel, next_lim_sel;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;

  // Data is fetched in setup so the access phase answers at once
  always_comb begin
    logic setup, wr;
    setup = psel && !penable;
    wr = psel && penable && pready && pwrite;
    next_irq_stat = irq_stat | evt;
    next_irq_mask = irq_mask;
    next_lim_sel = lim_sel;
    next_prdata = prdata;
    next_pslverr = 1'b0; // Stands for the access cycle only
    next_pready = setup;
    if (wr && !pslverr) begin
      unique case (paddr)
        // Clear by one; a new event in the same cycle survives
        `PCD_REG_IRQ_STAT: next_irq_stat = (irq_stat & ~pwdata[3:0]) | evt;
        `PCD_REG_IRQ_MASK: next_irq_mask = pwdata[3:0];
        `PCD_REG_LIM_SEL: next_lim_sel = pwdata[2:0];
        default: next_lim_sel = lim_sel;
      endcase
    end
    if (setup) begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (paddr)
        `PCD_REG_IRQ_STAT: next_prdata[3:0] = irq_stat;
        `PCD_REG_IRQ_MASK: next_prdata[3:0] = irq_mask;
        `PCD_REG_TRIP: begin
          for (int i = 0; i < NCH; i++) begin
            next_prdata[2*i +: 2] = trip[i];
          end
        end
        `PCD_REG_BATTLE: next_prdata[7:0] = battle_mode;
        `PCD_REG_GROUP: begin
          for (int i = 0; i < NCH; i++) begin
            next_prdata[4*i +: 4] = grp[i];
          end
        end
        `PCD_REG_LIM_SEL: next_prdata[2:0] = lim_sel;
        `PCD_REG_LIM_CUR: next_prdata = {lim_sc[lim_sel], lim_ovl[lim_sel]};
        `PCD_REG_LIM_THERM: next_prdata[15:0] = lim_thr[lim_sel];
        default: next_pslverr = 1'b1;
      endcase
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Bus and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
      irq_mask <= `PCD_RST_MASK;
      lim_sel <= 3'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      lim_sel <= next_lim_sel;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end
endmodule

// File: dv/pcd_decoder_checker.sv
// Port assertions for the channel command decoder
module pcd_decoder_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] sc_event,
  input wire logic [7:0] battle_mode,
  input wire logic [7:0] sc_retry,
  input wire logic restart,
  input wire logic update_abort
);
  // ------------------------------------------------------------------
  // Clocking and steps
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus setup cycle, head of a restart answer, a response byte held back
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence restart_head;
    tx_valid && tx_data == 8'h85;
  endsequence
  sequence stalled_byte;
    tx_valid && !tx_ready;
  endsequence

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  pready_timing_a: assert property (apb_setup |=> pready)
    else $error("pready missing in first access cycle");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  slverr_zero_a: assert property
    (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("refused access with nonzero data");
  tx_hold_a: assert property
    (stalled_byte |=> tx_valid && $stable(tx_data))
    else $error("response byte changed while stalled");
  rx_closed_a: assert property (tx_valid |-> !rx_ready)
    else $error("input open during a response");
  restart_resp_a: assert property (restart |-> restart_head)
    else $error("restart without its answer");
  restart_pulse_a: assert property (restart |=> !restart [*3])
    else $error("restart pulse repeated");
  abort_restart_a: assert property (update_abort |-> restart)
    else $error("update abort without restart");
  retry_battle_a: assert property
    (|(sc_event & battle_mode) |=>
      sc_retry == $past(sc_event & battle_mode))
    else $error("no retry for short on battle channel");
  retry_cause_a: assert property
    (sc_retry != 8'h00 |->
      (sc_retry & ~$past(sc_event & battle_mode)) == 8'h00)
    else $error("retry without battle short");
endmodule

bind pcd_decoder pcd_decoder_checker u_chk (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .rx_ready, .tx_valid, .tx_data, .tx_ready, .sc_event, .battle_mode,
  .sc_retry, .restart, .update_abort
);

// File: dv/pcd_host_model.sv
// Remote host model: sends command bytes, collects response bytes
module pcd_host_model (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // ------------------------------------------------------------------
  // One command and its four byte answer
  // ------------------------------------------------------------------
  // Stall holds the sink off so the answer must wait; a released data
  // line shows the inverse so a stale byte is never read twice
  task automatic xfer(input logic [95:0] m, input int n, input int stall,
                      output logic [31:0] r, output bit ok);
    int k;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_data <= m[8*(n-1-i) +: 8];
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (!rx_ready && k < 50);
      if (!rx_ready) ok = 1'b0;
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    repeat (stall) @(posedge pclk);
    tx_ready <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (!tx_valid && k < 50);
      if (!tx_valid) ok = 1'b0;
      r[31-8*i -: 8] = tx_data;
    end
    tx_ready <= 1'b0;
  endtask
endmodule

// File: dv/pcd_decoder_tb.sv
// Self-checking bench for the channel command decoder
module pcd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    int n;
    logic [95:0] m;
    logic [7:0] st;
    logic wp;
    logic bz;
  } pcd_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, irq;
  logic [7:0] rx_data, tx_data, battle_mode, sc_retry;
  logic [7:0] ovl_event = 8'h00, sc_event = 8'h00;
  logic update_busy = 1'b0, nv_write_protect = 1'b0;
  logic restart, update_abort;
  int abort_count = 0, restart_count = 0;
  int abort_base, restart_base;
  int miscompares = 0;
  int check_count = 0;

  // Commands in order: length, bytes, expected status, protect, busy
  pcd_row_t rows [18] = '{
    '{4, 96'h8200_0401, 8'h00, 1'b0, 1'b0},
    '{4, 96'h8200_0481, 8'h00, 1'b0, 1'b0},
    '{4, 96'h8200_0409, 8'h01, 1'b0, 1'b0},
    '{4, 96'h8200_0489, 8'h01, 1'b0, 1'b0},
    '{4, 96'h8200_0400, 8'h01, 1'b0, 1'b0},
    '{5, 96'h86_0005_0301, 8'h00, 1'b0, 1'b0},
    '{5, 96'h86_0005_0302, 8'h01, 1'b0, 1'b0},
    '{10, 96'h9000_0a02_0011_0022_0064, 8'h00, 1'b0, 1'b0},
    '{10, 96'h9000_0a02_0011_0022_0000, 8'h01, 1'b0, 1'b0},
    '{10, 96'h9000_0a02_0011_0022_1389, 8'h01, 1'b0, 1'b0},
    '{10, 96'h9000_0a02_0011_0022_1388, 8'h02, 1'b1, 1'b0},
    '{12, 96'h9200_0c02_0105_0000_0000_0000, 8'h00, 1'b0, 1'b0},
    '{12, 96'h9200_0c09_0105_0000_0000_0000, 8'h01, 1'b0, 1'b0},
    '{12, 96'h9200_0c02_0109_0000_0000_0000, 8'h01, 1'b0, 1'b0},
    '{5, 96'h82_0005_0100, 8'h01, 1'b0, 1'b0},
    '{4, 96'h8400_0400, 8'h01, 1'b0, 1'b1},
    '{3, 96'h84_0003, 8'h00, 1'b0, 1'b1},
    '{3, 96'h84_0003, 8'h00, 1'b0, 1'b0}
  };

  always #12.5 pclk = ~pclk;

  // Abort and restart are one-cycle pulses inside the answer, so count them
  always @(posedge pclk) begin
    if (update_abort === 1'b1) abort_count <= abort_count + 1;
    if (restart === 1'b1) restart_count <= restart_count + 1;
  end

  pcd_decoder u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_data, .rx_ready, .tx_valid,
    .tx_data, .tx_ready, .ovl_event, .sc_event, .update_busy,
    .nv_write_protect, .battle_mode, .sc_retry, .restart, .update_abort,
    .irq
  );

  pcd_host_model u_host (
    .pclk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready
  );

  // ------------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    miscompares++;
    $display("MISMATCH at %0t: %s", $time, what);
    report_and_stop();
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Answer code of each command, written out per command
  function automatic logic [7:0] resp_code(input logic [7:0] op);
    case (op)
      8'h82: return 8'h83;
      8'h84: return 8'h85;
      8'h86: return 8'h87;
      8'h90: return 8'h91;
      8'h92: return 8'h93;
      default: return 8'h00;
    endcase
  endfunction

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!pready && k < 20);
    if (!pready) hang("bus transfer not answered");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never re-drives psel now
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic err);
    logic [31:0] x;
    logic e;
    apb(1'b0, a, 32'h0000_0000, x, e);
    check(x, exp, "read data");
    check({31'b0, e}, {31'b0, err}, "slave error");
  endtask

  task automatic send(input logic [95:0] m, input int n,
                      input logic [7:0] st, input int stall);
    logic [31:0] r;
    bit ok;
    u_host.xfer(m, n, stall, r, ok);
    if (!ok) hang("message handshake stalled");
    check(r, {resp_code(m[8*n-1 -: 8]), 16'h0004, st}, "response");
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h04, 32'h0000_0000, 1'b0);
    check({31'b0, irq}, 32'h0000_0000, "irq after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      nv_write_protect <= rows[i].wp;
      update_busy <= rows[i].bz;
      abort_base = abort_count;
      restart_base = restart_count;
      send(rows[i].m, rows[i].n, rows[i].st, i % 3);
      check(abort_count - abort_base,
            {31'b0, rows[i].bz && rows[i].n == 3}, "abort");
      check(restart_count - restart_base, {31'b0, rows[i].n == 3},
            "restart");
    end
    $display("test command table done");
    check({24'b0, battle_mode}, 32'h0000_0004, "battle output");
    rd(8'h0c, 32'h0000_0004, 1'b0);
    rd(8'h10, 32'h0002_0002, 1'b0);
    wr(8'h14, 32'h0000_0001);
    rd(8'h18, 32'h0020_0010, 1'b0);
    rd(8'h1c, 32'h0000_1388, 1'b0);
    $display("test stored settings done");
    // Overload on the battle channel three must leave it untripped
    ovl_event <= 8'h05;
    sc_event <= 8'h02;
    @(posedge pclk);
    ovl_event <= 8'h00;
    sc_event <= 8'h00;
    @(posedge pclk);
    rd(8'h08, 32'h0000_0009, 1'b0);
    send(96'h8200_0482, 4, 8'h00, 2);
    rd(8'h08, 32'h0000_0008, 1'b0);
    send(96'h8200_0402, 4, 8'h00, 0);
    rd(8'h08, 32'h0000_0000, 1'b0);
    sc_event <= 8'h04;
    @(posedge pclk);
    sc_event <= 8'h00;
    @(posedge pclk);
    check({24'b0, sc_retry}, 32'h0000_0004, "retry pulse");
    $display("test trips done");
    rd(8'h00, 32'h0000_000f, 1'b0);
    wr(8'h04, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check({31'b0, irq}, 32'h0000_0001, "irq raised");
    wr(8'h00, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check({31'b0, irq}, 32'h0000_0000, "irq cleared");
    rd(8'h00, 32'h0000_000e, 1'b0);
    rd(8'h20, 32'h0000_0000, 1'b1);
    $display("test interrupts and map done");
    // Mid-run reset must drop every stored setting and latched event
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({24'b0, battle_mode}, 32'h0000_0000, "battle after reset");
    rd(8'h10, 32'h0000_0000, 1'b0);
    rd(8'h00, 32'h0000_0000, 1'b0);
    send(96'h84_0003, 3, 8'h00, 0);
    $display("test mid-run reset done");
    report_and_stop();
  end

  // Cuts a hung run short
  initial begin
    repeat (60000) @(posedge pclk);
    hang("run did not finish");
  end
endmodule
